/* File: core/pec_top.sv */
// Ungated pattern-checker error counting with an APB register slave.
`timescale 1ns/1ps
`include "pec_defs.svh"
module pec_top #(
  parameter int          LANES               = 8,
  parameter bit          LIVE_UPDATE_CAPABLE = 1'b1,
  parameter bit          PREV_SUPPORTED      = 1'b1,
  parameter int unsigned UPD_SHORT_CYCLES    = `PEC_IVAL_SHORT_CYC,
  parameter int unsigned UPD_LONG_CYCLES     = `PEC_IVAL_LONG_CYC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [2*LANES-1:0] chk_err,
  input  wire logic [2*LANES-1:0] chk_bit
);
  import pec_pkg::*;

  localparam int NCHK = 2 * LANES;

  logic [LANES-1:0]  host_en_reg,  host_en_next;
  logic [LANES-1:0]  media_en_reg, media_en_next;
  logic [NCHK-1:0]   en_d_reg,     en_d_next;
  pec_ctrl_type      ctrl_reg,     ctrl_next;
  logic [7:0]        sel_reg,      sel_next;
  logic [31:0]       prdata_reg,   prdata_next;
  logic              pready_reg,   pready_next;
  logic              pslverr_reg,  pslverr_next;
  logic [31:0]       upd_cnt_reg,  upd_cnt_next;

  logic [NCHK-1:0]   en_all;
  logic [NCHK-1:0]   rise_ev, fall_ev, rst_ev, rel_ev, clear_ev;
  logic [NCHK-1:0]   count_ok, snap_cur, snap_prev;
  logic              wr_stb, rd_setup, reset_write, reset_release;
  logic              upd_tick;
  logic [9:0]        idx;
  logic [31:0]       upd_limit;
  pec_view_type      live_v [NCHK];
  pec_view_type      cur_v  [NCHK];
  pec_view_type      prev_v [NCHK];

  // ************************************************************
  // APB decode.
  // ************************************************************
  assign idx      = paddr[11:2];
  assign wr_stb   = psel & penable & pready_reg & pwrite;
  assign rd_setup = psel & ~penable & ~pready_reg;
  assign en_all   = {media_en_reg, host_en_reg};

  always_comb begin
    host_en_next  = host_en_reg;
    media_en_next = media_en_reg;
    ctrl_next     = ctrl_reg;
    sel_next      = sel_reg;
    if (wr_stb) begin
      unique case (idx)
        `PEC_IDX_HOST_ENABLE:  host_en_next  = pwdata[LANES-1:0];
        `PEC_IDX_MEDIA_ENABLE: media_en_next = pwdata[LANES-1:0];
        `PEC_IDX_MEAS_CTRL:    ctrl_next     = pwdata[7:0];
        `PEC_IDX_RESULT_SEL:   sel_next      = pwdata[7:0];
        default:               ;
      endcase
    end
  end

  assign reset_write   = wr_stb && idx == `PEC_IDX_MEAS_CTRL &&
                         pwdata[`PEC_CTRL_RESET_BIT];
  assign reset_release = wr_stb && idx == `PEC_IDX_MEAS_CTRL &&
                         !pwdata[`PEC_CTRL_RESET_BIT] && ctrl_reg.reset_cnt;

  // Read data is prepared in the setup cycle so the access phase never
  // waits; unmapped indices answer with an error and zero data.
  always_comb begin
    logic [3:0]   ci;
    pec_view_type v;
    ci           = sel_reg[`PEC_SEL_IDX_MSB:0];
    v            = '0;
    for (int i = 0; i < NCHK; i++) begin
      if (ci == 4'(i)) begin
        v = sel_reg[`PEC_SEL_PREV_BIT] ? prev_v[i] : cur_v[i];
      end
    end
    pready_next  = rd_setup;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (rd_setup) begin
      prdata_next = 32'h0;
      unique case (idx)
        `PEC_IDX_CAPABILITY:
          prdata_next[`PEC_CAP_LIVE_BIT] = LIVE_UPDATE_CAPABLE;
        `PEC_IDX_HOST_ENABLE:  prdata_next[LANES-1:0] = host_en_reg;
        `PEC_IDX_MEDIA_ENABLE: prdata_next[LANES-1:0] = media_en_reg;
        `PEC_IDX_MEAS_CTRL:    prdata_next[7:0]       = ctrl_reg;
        `PEC_IDX_RESULT_SEL:   prdata_next[7:0]       = sel_reg;
        // Error and bit totals share a snapshot so elapsed time matches.
        `PEC_IDX_RESULT_ERRS:  prdata_next = v.errs;
        `PEC_IDX_RESULT_BITS:  prdata_next = v.bits;
        default:               pslverr_next = 1'b1;
      endcase
    end
  end

  // ************************************************************
  // Live update interval timer.
  // ************************************************************
  assign upd_limit = ctrl_reg.live_update_interval_sel ?
                     UPD_LONG_CYCLES : UPD_SHORT_CYCLES;
  assign upd_tick  = upd_cnt_reg >= upd_limit - 32'h1;

  always_comb begin
    upd_cnt_next = upd_tick ? 32'h0 : upd_cnt_reg + 32'h1;
  end

  // ************************************************************
  // Per lane events.
  // ************************************************************
  // Gating modes are not handled here: every gate duration value counts
  // continuously, which is exactly the ungated behaviour for 000b.
  // Refreshes raise no flag; the block has no interrupt output.
  for (genvar g = 0; g < NCHK; g++) begin : g_lane
    assign rise_ev[g]  = en_all[g] & ~en_d_reg[g];
    assign fall_ev[g]  = ~en_all[g] & en_d_reg[g];
    assign rst_ev[g]   = reset_write &
                         (ctrl_reg.scope_all | en_all[g]);
    assign rel_ev[g]   = reset_release & en_all[g];
    assign clear_ev[g] = rise_ev[g] | rst_ev[g] | rel_ev[g];
    assign count_ok[g] = en_all[g] & ~ctrl_reg.reset_cnt;
    // Ticks are held off while frozen, so the current view keeps the
    // pre-reset totals readable instead of the cleared live counters.
    assign snap_cur[g] = fall_ev[g] | rst_ev[g] |
                         (LIVE_UPDATE_CAPABLE & upd_tick & en_all[g] &
                          ~ctrl_reg.reset_cnt);
    assign snap_prev[g] = PREV_SUPPORTED & (fall_ev[g] | rst_ev[g]);

    pec_lane u_lane (
      .pclk        (pclk),
      .presetn     (presetn),
      .clear_i     (clear_ev[g]),
      .count_i     (count_ok[g]),
      .err_i       (chk_err[g]),
      .bit_i       (chk_bit[g]),
      .snap_cur_i  (snap_cur[g]),
      .snap_prev_i (snap_prev[g]),
      .live_o      (live_v[g]),
      .cur_o       (cur_v[g]),
      .prev_o      (prev_v[g])
    );
  end

  assign en_d_next = en_all;

  // ************************************************************
  // Registers.
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_en_reg  <= LANES'(`PEC_ENABLE_RESET);
      media_en_reg <= LANES'(`PEC_ENABLE_RESET);
      en_d_reg     <= '0;
      ctrl_reg     <= `PEC_CTRL_RESET;
      sel_reg      <= `PEC_SEL_RESET;
      prdata_reg   <= 32'h0;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      upd_cnt_reg  <= 32'h0;
    end else begin
      host_en_reg  <= host_en_next;
      media_en_reg <= media_en_next;
      en_d_reg     <= en_d_next;
      ctrl_reg     <= ctrl_next;
      sel_reg      <= sel_next;
      prdata_reg   <= prdata_next;
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
      upd_cnt_reg  <= upd_cnt_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ************************************************************
  // Assertions on host lane 0, media lane 0 and the shared timer.
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_enable_clears;
    rise_ev[0] |=> live_v[0] == '0;
  endproperty
  a_enable_clears: assert property (p_enable_clears)
    else $error("enable did not clear lane counters");

  property p_disable_snaps;
    fall_ev[0] |=> cur_v[0] == $past(live_v[0]) &&
                   (!PREV_SUPPORTED || prev_v[0] == $past(live_v[0]));
  endproperty
  a_disable_snaps: assert property (p_disable_snaps)
    else $error("disable did not publish results");

  property p_no_live_refresh;
    (!LIVE_UPDATE_CAPABLE && !fall_ev[0] && !rst_ev[0]) |=>
      $stable(cur_v[0]);
  endproperty
  a_no_live_refresh: assert property (p_no_live_refresh)
    else $error("current view changed without a stop");

  property p_live_refresh;
    (LIVE_UPDATE_CAPABLE && upd_tick && en_all[0] &&
     !ctrl_reg.reset_cnt) |=>
      cur_v[0] == $past(live_v[0]);
  endproperty
  a_live_refresh: assert property (p_live_refresh)
    else $error("live refresh missed");

  property p_bits_count;
    (count_ok[0] && chk_bit[0] && !clear_ev[0]) |=>
      live_v[0].bits == $past(live_v[0].bits) + 32'h1;
  endproperty
  a_bits_count: assert property (p_bits_count)
    else $error("bit total did not advance");

  property p_reset_enabled;
    (reset_write && !ctrl_reg.scope_all && en_all[0]) |=>
      live_v[0] == '0;
  endproperty
  a_reset_enabled: assert property (p_reset_enabled)
    else $error("reset missed an enabled lane");

  property p_reset_all;
    (reset_write && ctrl_reg.scope_all) |=> live_v[0] == '0;
  endproperty
  a_reset_all: assert property (p_reset_all)
    else $error("wide reset missed a lane");

  property p_reset_keeps_prev;
    (rst_ev[0] && PREV_SUPPORTED) |=> prev_v[0] == $past(live_v[0]) &&
                                      cur_v[0] == $past(live_v[0]);
  endproperty
  a_reset_keeps_prev: assert property (p_reset_keeps_prev)
    else $error("pre-reset totals not kept");

  property p_frozen;
    (ctrl_reg.reset_cnt && !clear_ev[0]) |=> $stable(live_v[0]);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("counters moved while frozen");

  property p_frozen_view;
    (ctrl_reg.reset_cnt && !fall_ev[0] && !rst_ev[0]) |=>
      $stable(cur_v[0]);
  endproperty
  a_frozen_view: assert property (p_frozen_view)
    else $error("current view changed while frozen");

  property p_prev_holds;
    (!fall_ev[0] && !rst_ev[0]) |=> $stable(prev_v[0]);
  endproperty
  a_prev_holds: assert property (p_prev_holds)
    else $error("previous view changed without a stop or reset");

  property p_media_enable_clears;
    rise_ev[LANES] |=> live_v[LANES] == '0;
  endproperty
  a_media_enable_clears: assert property (p_media_enable_clears)
    else $error("media enable did not clear lane counters");

  property p_release_clears;
    rel_ev[0] |=> live_v[0] == '0 ##1 !ctrl_reg.reset_cnt;
  endproperty
  a_release_clears: assert property (p_release_clears)
    else $error("release did not reset lane");

  property p_tick_restarts;
    upd_tick |=> upd_cnt_reg == 32'h0 ##1 upd_cnt_reg == 32'h1;
  endproperty
  a_tick_restarts: assert property (p_tick_restarts)
    else $error("interval timer did not restart");

endmodule : pec_top

/* File: core/pec_defs.svh */
// Offsets, field positions, reset values and timing counts of the checker.
`ifndef PEC_DEFS_SVH
`define PEC_DEFS_SVH

// ************************************************************
// Register indices; byte address is four times the index.
// ************************************************************
`define PEC_IDX_CAPABILITY   10'h081
`define PEC_IDX_HOST_ENABLE  10'h0a0
`define PEC_IDX_MEDIA_ENABLE 10'h0a8
`define PEC_IDX_MEAS_CTRL    10'h0b1
`define PEC_IDX_RESULT_SEL   10'h0c0
`define PEC_IDX_RESULT_ERRS  10'h0c1
`define PEC_IDX_RESULT_BITS  10'h0c2

// ************************************************************
// Field positions.
// ************************************************************
`define PEC_CAP_LIVE_BIT     4
`define PEC_CTRL_SCOPE_BIT   7
`define PEC_CTRL_RESET_BIT   5
`define PEC_CTRL_GATE_LSB    1
`define PEC_CTRL_GATE_MSB    3
`define PEC_CTRL_IVAL_BIT    0
`define PEC_SEL_PREV_BIT     4
`define PEC_SEL_IDX_MSB      3

// ************************************************************
// Reset values and encodings.
// ************************************************************
`define PEC_CTRL_RESET       8'h00
`define PEC_SEL_RESET        8'h00
`define PEC_ENABLE_RESET     8'h00
`define PEC_GATE_UNGATED     3'h0
`define PEC_CNT_W            32

// ************************************************************
// Timing.
// ************************************************************
`define PEC_CLK_HZ           200000000
`define PEC_IVAL_SHORT_S     1
`define PEC_IVAL_LONG_S      5
`define PEC_IVAL_SHORT_CYC   (`PEC_IVAL_SHORT_S * `PEC_CLK_HZ)
`define PEC_IVAL_LONG_CYC    (`PEC_IVAL_LONG_S * `PEC_CLK_HZ)

`endif

/* File: core/pec_pkg.sv */
// Types shared by the error counting logic.
package pec_pkg;
`include "pec_defs.svh"

  typedef struct packed {
    logic [`PEC_CNT_W-1:0] errs;
    logic [`PEC_CNT_W-1:0] bits;
  } pec_view_type;

  typedef struct packed {
    logic       scope_all;
    logic       spare6;
    logic       reset_cnt;
    logic       auto_restart;
    logic [2:0] gate_duration_field;
    logic       live_update_interval_sel;
  } pec_ctrl_type;

endpackage : pec_pkg

/* File: core/pec_lane.sv */
// One checker lane: live counters plus current and previous result views.
`timescale 1ns/1ps
module pec_lane (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clear_i,
  input  wire logic              count_i,
  input  wire logic              err_i,
  input  wire logic              bit_i,
  input  wire logic              snap_cur_i,
  input  wire logic              snap_prev_i,
  output pec_pkg::pec_view_type  live_o,
  output pec_pkg::pec_view_type  cur_o,
  output pec_pkg::pec_view_type  prev_o
);
  import pec_pkg::*;

  pec_view_type live_reg, live_next;
  pec_view_type cur_reg,  cur_next;
  pec_view_type prev_reg, prev_next;

  // ************************************************************
  // Counting and snapshots.
  // ************************************************************
  // Snapshots take the old live value, so a clear in the same cycle
  // still leaves the pre-clear totals visible.
  always_comb begin
    live_next = live_reg;
    if (clear_i) begin
      live_next = '0;
    end else if (count_i) begin
      if (bit_i) begin
        live_next.bits = live_reg.bits + 32'h1;
      end
      if (err_i) begin
        live_next.errs = live_reg.errs + 32'h1;
      end
    end
    cur_next  = snap_cur_i  ? live_reg : cur_reg;
    prev_next = snap_prev_i ? live_reg : prev_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_reg <= '0;
      cur_reg  <= '0;
      prev_reg <= '0;
    end else begin
      live_reg <= live_next;
      cur_reg  <= cur_next;
      prev_reg <= prev_next;
    end
  end

  assign live_o = live_reg;
  assign cur_o  = cur_reg;
  assign prev_o = prev_reg;

endmodule : pec_lane

/* File: dv/pec_host.sv */
// Host controller model: an APB master that issues one transfer per call.
`timescale 1ns/1ps
module pec_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // Released address and write data lines carry the inverse, so a stale value is never mistaken.
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e,
      output bit hung);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    hung = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : pec_host

/* File: dv/tb_top.sv */
// Self-checking bench for the ungated error counting block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) begin \
      n_fail++; \
      $display("mismatch %s exp %h got %h", nm, ex, got); \
    end \
  end
module tb_top;
  localparam int L = 2;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } pec_row_type;
  logic              pclk = 1'b0;
  logic              presetn;
  logic [2*L-1:0]    chk_err;
  logic [2*L-1:0]    chk_bit;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [31:0]       r;
  logic              e;
  int                n_fail = 0;
  int                compares = 0;
  pec_row_type       rows [6];

  always #2.5 pclk = ~pclk;

  pec_top #(.LANES(L), .UPD_SHORT_CYCLES(20), .UPD_LONG_CYCLES(100))
  i_pec_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chk_err(chk_err), .chk_bit(chk_bit));

  pec_host i_pec_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // ************************************************************
  // Shared tasks.
  // ************************************************************
  task automatic tally_and_finish;
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic acc(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic qe);
    bit hung;
    i_pec_host.xfer(w, a, d, q, qe, hung);
    if (hung) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : acc

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        qe;
    acc(1'b1, a, d, q, qe);
  endtask : wr

  // Results are polled, since no flag marks a refresh.
  task automatic view(input logic [7:0] s, input logic [31:0] xe, xb);
    logic [31:0] q;
    logic        qe;
    wr(12'h300, {24'h0, s});
    acc(1'b0, 12'h304, 32'h0, q, qe);
    `CHK("errs", xe, q)
    acc(1'b0, 12'h308, 32'h0, q, qe);
    `CHK("bits", xb, q)
  endtask : view

  // Checked bits 0, every, 2*every and so on are also flagged as errored.
  task automatic pulse(input int n, input logic [3:0] m, input int every);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      chk_bit <= m;
      chk_err <= (i % every == 0) ? m : 4'h0;
    end
    @(posedge pclk);
    chk_bit <= 4'h0;
    chk_err <= 4'h0;
  endtask : pulse

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    presetn = 1'b0;
    chk_err = 4'h0;
    chk_bit = 4'h0;
    rows[0] = '{12'h280, 32'h3, 32'h3, 1'b0};
    rows[1] = '{12'h2a0, 32'h1, 32'h1, 1'b0};
    rows[2] = '{12'h2c4, 32'h81, 32'h81, 1'b0};
    rows[3] = '{12'h300, 32'h10, 32'h10, 1'b0};
    rows[4] = '{12'h204, 32'hff, 32'h10, 1'b0};
    rows[5] = '{12'h040, 32'h5, 32'h0, 1'b1};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, 12'h2c4, 32'h0, r, e);
    `CHK("ctrl_rst", 32'h0, r)
    foreach (rows[i]) begin
      acc(1'b1, rows[i].a, rows[i].d, r, e);
      acc(1'b0, rows[i].a, 32'h0, r, e);
      `CHK("rd", rows[i].x, r)
      `CHK("err", rows[i].e, e)
    end
    wr(12'h280, 32'h0);
    wr(12'h2a0, 32'h0);
    wr(12'h2c4, 32'h0);
    wr(12'h280, 32'h1);
    pulse(10, 4'h1, 3);
    wr(12'h280, 32'h0);
    view(8'h00, 32'd4, 32'd10);
    view(8'h10, 32'd4, 32'd10);
    wr(12'h280, 32'h1);
    pulse(4, 4'h1, 4);
    wr(12'h280, 32'h0);
    view(8'h00, 32'd1, 32'd4);
    wr(12'h280, 32'h1);
    pulse(6, 4'h1, 3);
    wr(12'h2c4, 32'h20);
    view(8'h10, 32'd2, 32'd6);
    pulse(5, 4'h1, 1);
    repeat (20) @(posedge pclk);
    view(8'h00, 32'd2, 32'd6);
    wr(12'h2c4, 32'h0);
    pulse(3, 4'h1, 3);
    wr(12'h280, 32'h0);
    view(8'h00, 32'd1, 32'd3);
    wr(12'h280, 32'h1);
    pulse(5, 4'h1, 5);
    repeat (25) @(posedge pclk);
    view(8'h00, 32'd1, 32'd5);
    wr(12'h2c4, 32'h1);
    pulse(7, 4'h1, 7);
    repeat (110) @(posedge pclk);
    view(8'h00, 32'd2, 32'd12);
    // Poll the bit total until a refresh shows it, which aligns the bench
    // to the interval timer; a short interval would refresh too early.
    pulse(3, 4'h1, 3);
    for (int k = 0; k < 80 && r !== 32'd15; k++) begin
      acc(1'b0, 12'h308, 32'h0, r, e);
    end
    `CHK("tick", 32'd15, r)
    pulse(3, 4'h1, 3);
    repeat (30) @(posedge pclk);
    view(8'h00, 32'd3, 32'd15);
    repeat (70) @(posedge pclk);
    view(8'h00, 32'd4, 32'd18);
    // Wide scope reaches a disabled lane: the second reset snapshots zero.
    wr(12'h280, 32'h0);
    wr(12'h2c4, 32'h81);
    wr(12'h2c4, 32'ha1);
    view(8'h10, 32'd4, 32'd18);
    wr(12'h2c4, 32'h81);
    wr(12'h2c4, 32'ha1);
    view(8'h10, 32'd0, 32'd0);
    tally_and_finish();
  end
endmodule : tb_top
